/* File: hdl/cmd_slave_params.svh */
// Constants for the serial command slave: codes, lengths, timing.
// Assumes a 200 MHz clock and a UART on the same clock.
`ifndef CMD_SLAVE_PARAMS_SVH
`define CMD_SLAVE_PARAMS_SVH
`define FN_READ      8'h03
`define FN_WRITE     8'h06
`define FN_IDENT     8'h2b
`define MEI_TYPE     8'h0e
`define ID_ACCESS    8'h01
`define ID_CONFORM   8'h01
`define ID_MORE      8'h00
`define ID_NEXT      8'h00
`define ID_LAST_OBJ  8'h02
`define EXC_FLAG     8'h80
`define EXC_FUNC     8'h01
`define EXC_ADDR     8'h02
`define EXC_VALUE    8'h03
`define CRC_PRESET   16'hffff
`define CRC_POLY     16'ha001
`define READ_MAX     16'h000a
`define LEN_RW       4'h8
`define LEN_IDENT    4'h7
`define LEN_MIN      4'h4
`define RX_DEPTH     8
`define HDR_READ     8'h03
`define HDR_ECHO     8'h06
`define HDR_IDENT    8'h08
`define CLK_PERIOD_NS 5
// 3.5 characters of 11 bits at 9600 baud
`define GAP_TIME_NS  4010417
`endif

/* File: hdl/cmd_slave_pkg.sv */
// Types shared by the command slave.
// Assumes the constants header is available.
package cmd_slave_pkg;
   // Kind of reply being sent
   typedef enum logic [1:0] {REP_READ, REP_ECHO, REP_IDENT, REP_EXC}
      reply_kind_t;
   // Decoded reply descriptor
   typedef struct packed {
      reply_kind_t kind;
      logic [7:0]  code;
      logic [7:0]  count;
      logic [15:0] start;
      logic [1:0]  obj;
   } reply_t;
   // One byte travelling through the transmit buffer
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } beat_t;
endpackage

/* File: hdl/cmd_slave.sv */
// Serial command slave: read registers, write one, read identity.
// Assumes a UART on clk delivering bytes and taking them by handshake.
//
// Behaviour
// - Registers travel as 16-bit words
// - Read request: addr, 0x03, start, count, CRC
// - Read returns ascending consecutive registers
// - Read reply byte count is twice count
// - Each word sent high byte first
// - Write request: addr, 0x06, register, value, CRC
// - Successful write echoes the request exactly
// - Identity uses 0x2B then type 0x0E
// - Identity access type byte is 0x01
// - Identity conformity level is always 0x01
// - Identity more-follows byte is always 0x00
// - Identity next-object byte is always 0x00
// - Identity reply gives object count first
// - Object sent as number, length, characters
// - CRC16 low byte first; bad CRC silent
// - 3.5 character gaps around frames, replies
// - Exception: function with top bit, code
// - Codes 1 function, 2 address, 3 value
`include "cmd_slave_params.svh"
module cmd_slave
#(
   parameter int          NREGS      = 16,
   parameter logic [15:0] REG_BASE   = 16'h0300,
   parameter logic [15:0] MAX_VALUE  = 16'hffff,
   parameter int          GAP_CYCLES =
      (`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   // Identity strings: values are arbitrary
   parameter int          VEND_LEN   = 4,
   parameter int          PROD_LEN   = 8,
   parameter int          REV_LEN    = 3,
   parameter logic [8*VEND_LEN-1:0] VEND_STR = "VNDR",
   parameter logic [8*PROD_LEN-1:0] PROD_STR = "PRODUCT1",
   parameter logic [8*REV_LEN-1:0]  REV_STR  = "R01"
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  own_addr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        tx_ready,
   input  wire logic        tx_idle,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic             line_drive,
   output logic             wr_strobe,
   output logic [15:0]      wr_addr,
   output logic [15:0]      wr_data
);
   localparam int IW = $clog2(NREGS);
   localparam int GW = $clog2(GAP_CYCLES + 1);
   localparam int BL = 6 + VEND_LEN + PROD_LEN + REV_LEN;
   localparam logic [8*BL-1:0] BLOB = {8'h00, 8'(VEND_LEN), VEND_STR,
      8'h01, 8'(PROD_LEN), PROD_STR, 8'h02, 8'(REV_LEN), REV_STR};
   localparam logic [16:0] LIMIT = 17'(REG_BASE) + 17'(NREGS);

   typedef enum {S_RECV, S_DECODE, S_LEAD, S_SEND, S_DRAIN, S_TRAIL}
      state_t;

   state_t                state_reg, state_next;
   logic [7:0]            rx_buf_reg [`RX_DEPTH];
   logic [3:0]            rx_cnt_reg;
   logic [15:0]           rx_crc_reg, tx_crc_reg;
   logic [GW-1:0]         gap_reg;
   logic [15:0]           regs_reg [NREGS];
   cmd_slave_pkg::reply_t rep_reg, rep_next;
   logic [7:0]            len_reg, len_next, idx_reg;
   cmd_slave_pkg::beat_t  skid_reg;
   logic                  gap_done, push, discard, do_write;
   logic [7:0]            push_data, gen_byte;

   //////////////////////////////////////////////////////////////////
   // CRC16 step over one byte, LSB first
   function automatic logic [15:0] crc_step(logic [15:0] c,
                                            logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++)
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      return r;
   endfunction

   //////////////////////////////////////////////////////////////////
   // Silence timer; restarts on each byte received in S_RECV and each state change
   assign gap_done = (gap_reg == GW'(GAP_CYCLES));
   always_ff @(posedge clk or posedge reset)
      if (reset)
         gap_reg <= '0;
      else if (state_reg != state_next ||
               (state_reg == S_RECV && rx_valid))
         gap_reg <= '0;
      else if (!gap_done)
         gap_reg <= gap_reg + GW'(1);

   // Receive bytes; extras beyond the buffer only mark overflow
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         rx_cnt_reg <= '0;
         rx_crc_reg <= `CRC_PRESET;
      end
      else if (state_reg == S_DECODE)
      begin
         rx_cnt_reg <= '0;
         rx_crc_reg <= `CRC_PRESET;
      end
      else if (state_reg == S_RECV && rx_valid)
      begin
         if (rx_cnt_reg <= 4'(`RX_DEPTH))
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
         rx_crc_reg <= crc_step(rx_crc_reg, rx_data);
      end

   // Buffer storage has no reset; only counted bytes are read
   always_ff @(posedge clk)
      if (state_reg == S_RECV && rx_valid &&
          rx_cnt_reg < 4'(`RX_DEPTH))
         rx_buf_reg[rx_cnt_reg[2:0]] <= rx_data;

   //////////////////////////////////////////////////////////////////
   // Request decode, evaluated in the decode state
   logic [15:0] w1, w2;
   logic [16:0] rd_end;
   assign w1 = {rx_buf_reg[2], rx_buf_reg[3]};
   assign w2 = {rx_buf_reg[4], rx_buf_reg[5]};
   assign rd_end = {1'b0, w1} + {1'b0, w2};

   always_comb
   begin
      rep_next = rep_reg;
      rep_next.kind = cmd_slave_pkg::REP_EXC;
      rep_next.code = `EXC_FUNC;
      rep_next.count = w2[7:0];
      rep_next.start = w1 - REG_BASE;
      rep_next.obj = rx_buf_reg[4][1:0];
      do_write = 1'b0;
      // Bad CRC, foreign address, runt or overlong: no answer
      discard = rx_crc_reg != 16'h0000 ||
                rx_cnt_reg < `LEN_MIN ||
                rx_cnt_reg > 4'(`RX_DEPTH) ||
                rx_buf_reg[0] != own_addr;
      case (rx_buf_reg[1])
         `FN_READ:
         begin
            discard = discard || rx_cnt_reg != `LEN_RW;
            if (w2 == 16'h0000 || w2 > `READ_MAX)
               rep_next.code = `EXC_VALUE;
            else if (w1 < REG_BASE || rd_end > LIMIT)
               rep_next.code = `EXC_ADDR;
            else
               rep_next.kind = cmd_slave_pkg::REP_READ;
         end
         `FN_WRITE:
         begin
            discard = discard || rx_cnt_reg != `LEN_RW;
            if (w1 < REG_BASE || {1'b0, w1} >= LIMIT)
               rep_next.code = `EXC_ADDR;
            else if (w2 > MAX_VALUE)
               rep_next.code = `EXC_VALUE;
            else
            begin
               rep_next.kind = cmd_slave_pkg::REP_ECHO;
               do_write = !discard;
            end
         end
         `FN_IDENT:
         begin
            discard = discard || rx_cnt_reg != `LEN_IDENT;
            if (rx_buf_reg[2] != `MEI_TYPE)
               rep_next.code = `EXC_FUNC;
            else if (rx_buf_reg[3] != `ID_ACCESS ||
                     rx_buf_reg[4] > `ID_LAST_OBJ)
               rep_next.code = `EXC_VALUE;
            else
               rep_next.kind = cmd_slave_pkg::REP_IDENT;
         end
         default: ;
      endcase
   end

   // Offset of the starting object inside the identity blob
   logic [7:0] obj_off;
   always_comb
      case (rep_next.obj)
         2'h0:    obj_off = 8'h00;
         2'h1:    obj_off = 8'(2 + VEND_LEN);
         default: obj_off = 8'(4 + VEND_LEN + PROD_LEN);
      endcase

   // Payload length, CRC excluded
   always_comb
      case (rep_next.kind)
         cmd_slave_pkg::REP_READ:
            len_next = `HDR_READ + {w2[6:0], 1'b0};
         cmd_slave_pkg::REP_ECHO:  len_next = `HDR_ECHO;
         cmd_slave_pkg::REP_IDENT:
            len_next = `HDR_IDENT + 8'(BL) - obj_off;
         default:                  len_next = `EXC_FLAG ^ `EXC_FLAG
                                              ^ `HDR_READ;
      endcase

   //////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         S_RECV:
            if (gap_done && rx_cnt_reg != 4'h0)
               state_next = S_DECODE;
         S_DECODE:
            state_next = discard ? S_RECV : S_LEAD;
         S_LEAD:
            if (gap_done)
               state_next = S_SEND;
         S_SEND:
            if (push && idx_reg == len_reg + 8'h01)
               state_next = S_DRAIN;
         S_DRAIN:
            if (!tx_valid && !skid_reg.valid && tx_idle)
               state_next = S_TRAIL;
         S_TRAIL:
            if (gap_done)
               state_next = S_RECV;
         default:
            state_next = S_RECV;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
      if (reset)
         state_reg <= S_RECV;
      else
         state_reg <= state_next;

   // Line held from decode through the trailing gap
   always_ff @(posedge clk or posedge reset)
      if (reset)
         line_drive <= 1'b0;
      else if (state_reg == S_DECODE)
         line_drive <= !discard;
      else if (state_reg == S_TRAIL && gap_done)
         line_drive <= 1'b0;

   // Latch the reply descriptor
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         rep_reg <= '0;
         len_reg <= '0;
      end
      else if (state_reg == S_DECODE)
      begin
         rep_reg <= rep_next;
         len_reg <= len_next;
      end

   //////////////////////////////////////////////////////////////////
   // Register store, always whole 16-bit words
   always_ff @(posedge clk or posedge reset)
      if (reset)
         for (int i = 0; i < NREGS; i++)
            regs_reg[i] <= '0;
      else if (state_reg == S_DECODE && do_write)
         regs_reg[IW'(rep_next.start)] <= w2;

   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         wr_strobe <= 1'b0;
         wr_addr   <= '0;
         wr_data   <= '0;
      end
      else
      begin
         wr_strobe <= state_reg == S_DECODE && do_write;
         if (state_reg == S_DECODE && do_write)
         begin
            wr_addr <= w1;
            wr_data <= w2;
         end
      end

   //////////////////////////////////////////////////////////////////
   // Reply byte generator, indexed by byte position
   logic [7:0]    rel;
   logic [15:0]   word;
   int            bj;
   assign rel = idx_reg - `HDR_READ;
   assign word = regs_reg[IW'(rep_reg.start + 16'(rel[7:1]))];

   always_comb
   begin
      bj = int'(idx_reg) - int'(`HDR_IDENT) + ((rep_reg.obj == 2'h0) ?
           0 : (rep_reg.obj == 2'h1) ? 2 + VEND_LEN
           : 4 + VEND_LEN + PROD_LEN);
      if (bj < 0 || bj >= BL)
         bj = 0;
      gen_byte = rx_buf_reg[0];
      if (idx_reg == 8'h01)
         gen_byte = (rep_reg.kind == cmd_slave_pkg::REP_EXC) ?
                    (rx_buf_reg[1] | `EXC_FLAG) : rx_buf_reg[1];
      else if (idx_reg != 8'h00)
         case (rep_reg.kind)
            cmd_slave_pkg::REP_READ:
               if (idx_reg == 8'h02)
                  gen_byte = {rep_reg.count[6:0], 1'b0};
               else
                  gen_byte = rel[0] ? word[7:0] : word[15:8];
            cmd_slave_pkg::REP_ECHO:
               gen_byte = rx_buf_reg[idx_reg[2:0]];
            cmd_slave_pkg::REP_IDENT:
               case (idx_reg)
                  8'h02:   gen_byte = `MEI_TYPE;
                  8'h03:   gen_byte = `ID_ACCESS;
                  8'h04:   gen_byte = `ID_CONFORM;
                  8'h05:   gen_byte = `ID_MORE;
                  8'h06:   gen_byte = `ID_NEXT;
                  8'h07:   gen_byte = `ID_LAST_OBJ + 8'h01
                                      - 8'(rep_reg.obj);
                  default: gen_byte = BLOB[8*(BL-1-bj) +: 8];
               endcase
            default:
               gen_byte = rep_reg.code;
         endcase
   end

   // Payload then CRC, low byte first
   assign push = state_reg == S_SEND && !skid_reg.valid;
   assign push_data = (idx_reg == len_reg) ? tx_crc_reg[7:0] :
                      (idx_reg > len_reg) ? tx_crc_reg[15:8] : gen_byte;

   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         idx_reg    <= '0;
         tx_crc_reg <= `CRC_PRESET;
      end
      else if (state_reg == S_DECODE)
      begin
         idx_reg    <= '0;
         tx_crc_reg <= `CRC_PRESET;
      end
      else if (push)
      begin
         idx_reg <= idx_reg + 8'h01;
         if (idx_reg < len_reg)
            tx_crc_reg <= crc_step(tx_crc_reg, gen_byte);
      end

   //////////////////////////////////////////////////////////////////
   // Two-entry buffer: output stage plus skid, so a stall loses nothing
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         tx_valid <= 1'b0;
         tx_data  <= '0;
         skid_reg <= '0;
      end
      else if (!tx_valid || tx_ready)
      begin
         if (skid_reg.valid)
         begin
            tx_data        <= skid_reg.data;
            tx_valid       <= 1'b1;
            skid_reg.valid <= 1'b0;
         end
         else
         begin
            tx_valid <= push;
            if (push)
               tx_data <= push_data;
         end
      end
      else if (push)
         skid_reg <= '{valid: 1'b1, data: push_data};

   //////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_crc_silent: assert property (state_reg == S_DECODE &&
      rx_crc_reg != 16'h0000 |=> state_reg == S_RECV && !line_drive)
      else $error("bad CRC frame answered");
   a_addr_silent: assert property (state_reg == S_DECODE &&
      rx_buf_reg[0] != own_addr |=> state_reg == S_RECV ##1 !line_drive)
      else $error("foreign frame answered");
   a_lead_gap: assert property ($rose(state_reg == S_SEND)
      |-> $past(gap_reg) == GW'(GAP_CYCLES) && line_drive)
      else $error("reply started before gap");
   a_read_count: assert property (push && idx_reg == 8'h02 &&
      rep_reg.kind == cmd_slave_pkg::REP_READ
      |-> push_data == 8'(2 * rep_reg.count))
      else $error("byte count not twice count");
   // A one-word read has its CRC at this position, so it is left out
   a_read_order: assert property (push && idx_reg == 8'h05 &&
      idx_reg < len_reg && rep_reg.kind == cmd_slave_pkg::REP_READ
      |-> push_data == regs_reg[IW'(rep_reg.start + 16'h1)][15:8])
      else $error("second word out of order");
   a_word_msb: assert property (push && idx_reg == 8'h03 &&
      rep_reg.kind == cmd_slave_pkg::REP_READ
      |-> push_data == regs_reg[IW'(rep_reg.start)][15:8])
      else $error("high byte not first");
   a_echo_copy: assert property (push && idx_reg < 8'h06 &&
      rep_reg.kind == cmd_slave_pkg::REP_ECHO
      |-> push_data == rx_buf_reg[idx_reg[2:0]])
      else $error("echo differs from request");
   a_write_store: assert property (state_reg == S_DECODE &&
      do_write |=> regs_reg[IW'($past(rep_next.start))] == $past(w2)
      ##1 !wr_strobe)
      else $error("write not stored");
   a_ident_fixed: assert property (push && idx_reg == 8'h04 &&
      rep_reg.kind == cmd_slave_pkg::REP_IDENT
      |-> push_data == `ID_CONFORM ##1 push_data == `ID_MORE)
      else $error("fixed identity bytes wrong");
   a_ident_count: assert property (push && idx_reg == 8'h07 &&
      rep_reg.kind == cmd_slave_pkg::REP_IDENT
      |-> push_data == 8'h03 - 8'(rep_reg.obj))
      else $error("object count wrong");
   a_exc_func: assert property (push && idx_reg == 8'h01 &&
      rep_reg.kind == cmd_slave_pkg::REP_EXC
      |-> push_data[7] && $stable(line_drive))
      else $error("exception flag missing");

   c_read: cover property (rep_reg.kind == cmd_slave_pkg::REP_READ
      && state_reg == S_TRAIL);
   c_write: cover property (wr_strobe);
   c_ident: cover property (rep_reg.kind == cmd_slave_pkg::REP_IDENT
      && state_reg == S_TRAIL);
   c_stall: cover property (skid_reg.valid && tx_valid && !tx_ready);
endmodule // cmd_slave

/* File: tb/tx_uart_model.sv */
// Transmit UART stand-in: takes bytes by valid/ready and keeps them.
// Assumes the slave's clock; slow mode stalls ready and shifts longer.
module tx_uart_model
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            tx_idle
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got [$];
   logic [3:0] busy_reg;
   logic       phase_reg;
   ////////////////////////////////////////////////////////////////////////
   // Ready drops while shifting, and every other cycle when slow
   assign tx_ready = (busy_reg == 4'h0) && !(slow && phase_reg);
   assign tx_idle  = (busy_reg == 4'h0);
   // Shifter goes busy the cycle after an accept, as the slave expects
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         busy_reg  <= 4'h0;
         phase_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= ~phase_reg;
         if (tx_valid && tx_ready)
         begin
            got.push_back(tx_data);
            busy_reg <= slow ? 4'hc : 4'h3;
         end
         else if (busy_reg != 4'h0)
            busy_reg <= busy_reg - 4'h1;
      end
   end
endmodule // tx_uart_model

/* File: tb/test_cmd_slave.sv */
// Bench for the command slave: request frames in, replies byte-checked.
// Assumes the UART stand-in of tx_uart_model.sv on the transmit side.
module test_cmd_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP = 20;
   typedef logic [7:0] bytes_t [$];
   logic        clk        = 1'b0;
   logic        reset      = 1'b1;
   logic [7:0]  own_addr   = 8'h11;
   logic        rx_valid   = 1'b0;
   logic [7:0]  rx_data    = 8'h00;
   logic        slow       = 1'b0;
   logic        tx_ready;
   logic        tx_idle;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        line_drive;
   logic        wr_strobe;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   int          bad_count  = 0;
   int          num_checks = 0;
   int          strobes    = 0;
   ////////////////////////////////////////////////////////////////////////
   cmd_slave #(.GAP_CYCLES(GAP)) i_dut
   (
      .clk(clk), .reset(reset), .own_addr(own_addr), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_ready(tx_ready), .tx_idle(tx_idle),
      .tx_valid(tx_valid), .tx_data(tx_data), .line_drive(line_drive),
      .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data)
   );
   tx_uart_model i_uart
   (
      .clk(clk), .reset(reset), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .tx_idle(tx_idle)
   );
   // 200 MHz clock
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // Write pulses counted so a double strobe shows up
   always @(posedge clk)
   begin
      if (wr_strobe === 1'b1)
         strobes++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s saw %h expected %h",
                  $time, what, seen, exp);
      end
   endtask
   // Reference CRC, byte by byte, low bit first
   function automatic logic [15:0] crc16(input bytes_t b);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i])
      begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   function automatic bytes_t framed(input bytes_t b);
      logic [15:0] c;
      c = crc16(b);
      return {b, c[7:0], c[15:8]};
   endfunction
   // One request out, reply gathered; empty exp means no reply at all
   task automatic run(input bytes_t req, input bytes_t exp,
                      input string what, input bit bad = 1'b0);
      int     n;
      int     m;
      bytes_t f;
      bytes_t want;
      i_uart.got.delete();
      f = framed(req);
      if (bad)
         f[f.size()-1] ^= 8'h01;
      foreach (f[i])
      begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data  <= f[i];
         @(posedge clk);
         rx_valid <= 1'b0;
      end
      n = 0;
      while (line_drive !== 1'b1 && n < 3 * GAP)
      begin
         @(negedge clk);
         n++;
      end
      if (exp.size() == 0)
         check(line_drive, 1'b0, {what, " silent"});
      else
      begin
         want = framed(exp);
         n = 0;
         while (tx_valid !== 1'b1 && n < 4 * GAP)
         begin
            @(negedge clk);
            n++;
         end
         check(n >= GAP, 1'b1, {what, " lead gap"});
         n = 0;
         m = 0;
         while (line_drive === 1'b1 && n < 4000)
         begin
            @(negedge clk);
            n++;
            m = (tx_idle === 1'b1 && tx_valid === 1'b0) ? m + 1 : 0;
         end
         check(m >= GAP, 1'b1, {what, " trail gap"});
         check(i_uart.got.size(), want.size(), {what, " length"});
         foreach (want[i])
            check(i_uart.got[i], want[i], what);
      end
      $display("test done: %s", what);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      run('{8'h11, 8'h06, 8'h03, 8'h05, 8'ha5, 8'h5a},
          '{8'h11, 8'h06, 8'h03, 8'h05, 8'ha5, 8'h5a}, "write echo");
      check(strobes, 1, "write strobes");
      check(wr_addr, 16'h0305, "write address");
      check(wr_data, 16'ha55a, "write value");
   endtask
   // Stalling UART; the written word sits between two reset words
   task automatic t_read();
      slow = 1'b1;
      run('{8'h11, 8'h03, 8'h03, 8'h04, 8'h00, 8'h03},
          '{8'h11, 8'h03, 8'h06, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'h00, 8'h00},
          "read three");
      check(i_uart.got[2], 8'h06, "byte count");
      check(i_uart.got[5], 8'ha5, "high byte first");
      slow = 1'b0;
   endtask
   // Largest count, ending exactly at the top of the register area
   task automatic t_read_ten();
      bytes_t e;
      e = '{8'h11, 8'h03, 8'h14};
      repeat (20)
         e.push_back(8'h00);
      run('{8'h11, 8'h03, 8'h03, 8'h06, 8'h00, 8'h0a}, e, "read ten");
      check(i_uart.got[2], 8'h14, "ten byte count");
   endtask
   task automatic t_except();
      run('{8'h11, 8'h03, 8'h03, 8'h00, 8'h00, 8'h0b},
          '{8'h11, 8'h83, 8'h03}, "count eleven");
      run('{8'h11, 8'h03, 8'h03, 8'h0f, 8'h00, 8'h02},
          '{8'h11, 8'h83, 8'h02}, "read past end");
      run('{8'h11, 8'h06, 8'h02, 8'hff, 8'h00, 8'h01},
          '{8'h11, 8'h86, 8'h02}, "write outside");
      run('{8'h11, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
          '{8'h11, 8'h84, 8'h01}, "unknown function");
      run('{8'h11, 8'h2b, 8'h0e, 8'h02, 8'h00},
          '{8'h11, 8'hab, 8'h03}, "bad access");
      run('{8'h11, 8'h2b, 8'h0e, 8'h01, 8'h03},
          '{8'h11, 8'hab, 8'h03}, "bad object");
      run('{8'h11, 8'h2b, 8'h0d, 8'h01, 8'h00},
          '{8'h11, 8'hab, 8'h01}, "bad type");
      run('{8'h11, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00},
          '{8'h11, 8'h83, 8'h03}, "count zero");
   endtask
   // Every starting object; list always runs up to the last one
   task automatic t_ident();
      bytes_t objs [3];
      bytes_t e;
      objs[0] = '{8'h00, 8'h04, 8'h56, 8'h4e, 8'h44, 8'h52};
      objs[1] = '{8'h01, 8'h08, 8'h50, 8'h52, 8'h4f, 8'h44,
                  8'h55, 8'h43, 8'h54, 8'h31};
      objs[2] = '{8'h02, 8'h03, 8'h52, 8'h30, 8'h31};
      for (int s = 0; s < 3; s++)
      begin
         e = '{8'h11, 8'h2b, 8'h0e, 8'h01, 8'h01, 8'h00, 8'h00};
         e.push_back(8'(3 - s));
         for (int k = s; k < 3; k++)
            e = {e, objs[k]};
         run('{8'h11, 8'h2b, 8'h0e, 8'h01, 8'(s)}, e, "identity");
         check(i_uart.got[4], 8'h01, "conformity");
         check(i_uart.got[5], 8'h00, "more follows");
         check(i_uart.got[6], 8'h00, "next object");
         check(i_uart.got[7], 8'(3 - s), "object count");
         check(i_uart.got[8], 8'(s), "first object");
      end
   endtask
   task automatic t_silent();
      bytes_t none;
      run('{8'h12, 8'h03, 8'h03, 8'h00, 8'h00, 8'h01}, none, "other addr");
      run('{8'h11, 8'h03, 8'h03, 8'h00, 8'h00, 8'h01}, none, "bad crc", 1'b1);
      check(i_uart.got.size(), 0, "nothing sent");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Whole run is near 2000 cycles; thirty times that means a hang
   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      wrap_up();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_write();
      t_read();
      t_read_ten();
      t_except();
      t_ident();
      t_silent();
      wrap_up();
   end
endmodule // test_cmd_slave
